/* File: dv/sac_adc_model.sv */
// sac_adc_model.sv: comparator seen by the converter control
// assumes level is the code at which the analog input sits
`timescale 1ns/1ps
module sac_adc_model (
  input wire logic [15:0] dac_code,
  input wire logic [15:0] level,
  output logic comp_hi
);
  // trial bit kept while the dac is not above the input
  assign comp_hi = (dac_code <= level);
endmodule

/* File: dv/sac_ctrl_checker.sv */
// sac_ctrl_checker.sv: port assertions for sac_ctrl
// assumes one clock and the synchronous active-low reset
`timescale 1ns/1ps
module sac_ctrl_checker (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic select_b,
  input wire logic read_conv,
  input wire logic busy_b,
  input wire logic hold,
  input wire logic [15:0] dac_code,
  input wire logic [15:0] result_bus_out,
  input wire logic result_bus_oe_b,
  input wire logic result_valid,
  input wire logic [15:0] result_data,
  input wire logic result_ready
);
  logic [12:0] low_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  always @(posedge clk_sys)
    if (!rst_b || busy_b) low_cnt <= 13'h0000;
    else low_cnt <= low_cnt + 13'h0001;
  chk_start_taken:
    assert property (busy_b && !select_b && !read_conv |=> !busy_b)
    else $error("start missed");
  chk_hold_busy:
    assert property (hold |-> !busy_b) else $error("hold outside busy");
  chk_hold_start:
    assert property ($fell(busy_b) |-> hold)
    else $error("no hold at start");
  chk_bus_float:
    assert property (!read_conv || select_b |=> result_bus_oe_b)
    else $error("bus driven");
  chk_bus_drive:
    assert property (!select_b && read_conv |=> !result_bus_oe_b)
    else $error("bus not driven");
  chk_msb_first:
    assert property ($fell(busy_b) |-> ##1 dac_code == 16'h8000)
    else $error("first trial wrong");
  chk_busy_span:
    assert property ($rose(busy_b) |-> low_cnt >= 13'h0570)
    else $error("busy too short");
  chk_busy_latched:
    assert property ($rose(busy_b) |-> $stable(result_bus_out))
    else $error("result moved at busy rise");
  chk_stream_hold:
    assert property (result_valid && !result_ready
      |=> result_valid && $stable(result_data))
    else $error("stream word dropped");
endmodule
bind sac_ctrl sac_ctrl_checker u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .select_b(select_b), .read_conv(read_conv), .busy_b(busy_b),
  .hold(hold), .dac_code(dac_code), .result_bus_out(result_bus_out),
  .result_bus_oe_b(result_bus_oe_b), .result_valid(result_valid),
  .result_data(result_data), .result_ready(result_ready));

/* File: dv/tb.sv */
// tb.sv: self-checking bench for sac_ctrl with a comparator model
// assumes design, model and checker are compiled first
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic select_b = 1'b1;
  logic read_conv = 1'b1;
  logic byte_swap = 1'b0;
  logic bipolar = 1'b0;
  logic result_ready = 1'b1;
  logic [15:0] level = 16'h0000;
  wire comp_hi, busy_b, hold, oe_b, result_valid;
  wire [15:0] dac_code, bus_out, result_data;
  int mismatches = 0;
  int check_count = 0;
  int n;
  always #2.5 clk_sys = ~clk_sys;
  sac_ctrl DUT (.clk_sys(clk_sys), .rst_b(rst_b), .select_b(select_b),
    .read_conv(read_conv), .byte_swap(byte_swap), .bipolar(bipolar),
    .comp_hi(comp_hi), .busy_b(busy_b), .hold(hold), .dac_code(dac_code),
    .result_bus_out(bus_out), .result_bus_oe_b(oe_b),
    .result_valid(result_valid), .result_data(result_data),
    .result_ready(result_ready));
  sac_adc_model adc (.dac_code(dac_code), .level(level), .comp_hi(comp_hi));
  task automatic check(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one conversion; n counts cycles from release until busy rises
  task automatic conv(input logic [15:0] lv, input bit sel, input bit again);
    level = lv;
    repeat (400) @(posedge clk_sys);
    read_conv <= 1'b0;
    if (sel) repeat (2) @(posedge clk_sys);
    select_b <= 1'b0;
    // 40 ns pulse, released long before busy rises
    repeat (8) @(posedge clk_sys);
    read_conv <= 1'b1;
    select_b <= sel;
    if (again) begin
      repeat (400) @(posedge clk_sys);
      read_conv <= 1'b0;
      repeat (8) @(posedge clk_sys);
      read_conv <= 1'b1;
    end
    n = again ? 408 : 0;
    do begin @(negedge clk_sys); n++; end
    while (busy_b !== 1'b1 && n < 3000);
  endtask
  task automatic t_tied();
    conv(16'ha5c3, 1'b0, 1'b1);
    check("span", 16'h0001, 16'(n >= 1392 && n <= 1492));
    check("tied read", 16'ha5c3, bus_out);
    check("tied oe", 16'h0000, 16'(oe_b));
    @(posedge clk_sys);
    byte_swap <= 1'b1;
    repeat (2) @(negedge clk_sys);
    check("swap", 16'hc3a5, bus_out);
    @(posedge clk_sys);
    byte_swap <= 1'b0;
  endtask
  task automatic t_select();
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      bipolar <= i[0];
      conv(i ? 16'h0001 : 16'hffff, 1'b1, 1'b0);
      check("sel oe", 16'h0001, 16'(oe_b));
      @(posedge clk_sys);
      select_b <= 1'b0;
      repeat (2) @(negedge clk_sys);
      check("sel read", i ? 16'h8001 : 16'hffff, bus_out);
      @(posedge clk_sys);
      select_b <= 1'b1;
    end
  endtask
  task automatic t_fifo();
    @(posedge clk_sys);
    bipolar <= 1'b0;
    result_ready <= 1'b0;
    // one word in the output register and eight queued; the tenth stalls
    for (int i = 0; i < 10; i++) conv(16'h1111 * i[15:0], 1'b0, 1'b0);
    check("stall", 16'h0bb8, 16'(n));
    @(posedge clk_sys);
    result_ready <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      n = 0;
      do begin @(negedge clk_sys); n++; end
      while (result_valid !== 1'b1 && n < 200);
      check("word", 16'h1111 * i[15:0], result_data);
    end
  endtask
  initial begin
    #300000;
    mismatches++;
    results();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_tied();
    t_select();
    t_fifo();
    results();
  end
endmodule

/* File: logic/sac_ctrl.v */
// sac_ctrl.v: conversion control of a 16-bit successive approximation
// converter with a three-state parallel result port.
// assumes select and read/convert are synchronous to clk_sys, and that
// the analog comparator answers within one bit period.
`timescale 1ns/1ps
`include "sac_defs.vh"
module sac_ctrl (
  input wire clk_sys,
  input wire rst_b,
  input wire select_b,
  input wire read_conv,
  input wire byte_swap,
  input wire bipolar,
  input wire comp_hi,
  output reg busy_b,
  output reg hold,
  output reg [15:0] dac_code,
  output reg [15:0] result_bus_out,
  output reg result_bus_oe_b,
  output reg result_valid,
  output reg [15:0] result_data,
  input wire result_ready
);
  localparam integer BIT_CYC_I = `SAC_BIT_CYC;
  localparam integer BUSY_CYC_I = `SAC_BUSY_CYC;
  localparam [11:0] BIT_CYC = BIT_CYC_I[11:0];
  localparam [11:0] BUSY_CYC = BUSY_CYC_I[11:0];

  ////////////////////////////////////////////////////////////////////////
  // format helpers; sac_code serves the port and the stream, sac_swap the port only
  function [15:0] sac_code;
    input [15:0] raw;
    input bip;
    begin
      // bipolar: offset binary to two's complement
      sac_code = bip ? {~raw[15], raw[14:0]} : raw;
    end
  endfunction

  function [15:0] sac_swap;
    input [15:0] val;
    input sw;
    begin
      sac_swap = sw ? {val[7:0], val[15:8]} : val;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  reg [1:0] state;
  reg [1:0] next_state;
  reg [15:0] sar;
  reg [15:0] out_latch;
  reg [3:0] bit_idx;
  reg [11:0] cnt;
  reg ctl_low_d;
  reg rc_d;
  wire ctl_low;
  wire start_req;
  wire bit_done;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [15:0] fifo_out_data;
  reg fifo_pop;

  // select is internally ored with read/convert
  assign ctl_low = !select_b && !read_conv;
  assign start_req = ctl_low && !ctl_low_d;
  assign bit_done = (cnt == BIT_CYC - 12'h001);

  always @* begin
    next_state = state;
    case (state)
      `SAC_ST_IDLE: begin
        if (start_req) begin
          next_state = `SAC_ST_CLEAR;
        end
      end
      `SAC_ST_CLEAR: begin
        next_state = `SAC_ST_DECIDE;
      end
      `SAC_ST_DECIDE: begin
        if (bit_done && bit_idx == 4'h0) begin
          next_state = `SAC_ST_LATCH;
        end
      end
      `SAC_ST_LATCH: begin
        // result waits if the stream is full, keeping busy low
        if (cnt >= BUSY_CYC && fifo_in_ready) begin
          next_state = `SAC_ST_IDLE;
        end
      end
      default: begin
        next_state = `SAC_ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= `SAC_ST_IDLE;
      sar <= 16'h0000;
      out_latch <= 16'h0000;
      bit_idx <= 4'hf;
      cnt <= 12'h000;
      ctl_low_d <= 1'b0;
      rc_d <= 1'b1;
      busy_b <= 1'b1;
      hold <= 1'b0;
      dac_code <= 16'h0000;
    end else begin
      // edges seen outside idle are dropped
      state <= next_state;
      ctl_low_d <= ctl_low;
      rc_d <= read_conv;
      case (state)
        `SAC_ST_IDLE: begin
          cnt <= 12'h000;
          if (start_req) begin
            busy_b <= 1'b0;
            hold <= 1'b1;
          end
        end
        `SAC_ST_CLEAR: begin
          sar <= 16'h0000;
          bit_idx <= 4'hf;
          dac_code <= 16'h8000;
          cnt <= 12'h000;
        end
        `SAC_ST_DECIDE: begin
          if (bit_done) begin
            cnt <= 12'h000;
            // msb first, one bit per period
            sar[bit_idx] <= comp_hi;
            if (bit_idx != 4'h0) begin
              dac_code <= (sar | (16'h0001 << bit_idx)) &
                ~(comp_hi ? 16'h0000 : (16'h0001 << bit_idx)) |
                (16'h0001 << (bit_idx - 4'h1));
              bit_idx <= bit_idx - 4'h1;
            end
          end else begin
            cnt <= cnt + 12'h001;
          end
        end
        `SAC_ST_LATCH: begin
          cnt <= (cnt == BUSY_CYC) ? cnt : cnt + 12'h001;
          hold <= 1'b0;
          if (cnt == 12'h000) begin
            out_latch <= sar;
          end
          if (next_state == `SAC_ST_IDLE) begin
            busy_b <= 1'b1;
          end
        end
        default: begin
          busy_b <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output drivers on the result port
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      result_bus_oe_b <= 1'b1;
      result_bus_out <= 16'h0000;
    end else begin
      if (select_b || !read_conv) begin
        result_bus_oe_b <= 1'b1;
      end else if (!rc_d || result_bus_oe_b) begin
        result_bus_oe_b <= 1'b0;
      end
      result_bus_out <= sac_swap(sac_code(out_latch, bipolar), byte_swap);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // finished results also stream out through the fifo
  always @* begin
    fifo_pop = fifo_out_valid && (!result_valid || result_ready);
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      result_valid <= 1'b0;
      result_data <= 16'h0000;
    end else if (fifo_pop) begin
      result_valid <= 1'b1;
      result_data <= fifo_out_data;
    end else if (result_ready) begin
      result_valid <= 1'b0;
    end
  end

  sac_fifo #(
    .WIDTH(`SAC_RES_BITS),
    .DEPTH(`SAC_FIFO_DEPTH),
    .AW(`SAC_FIFO_AW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .in_valid(state == `SAC_ST_LATCH && next_state == `SAC_ST_IDLE),
    .in_ready(fifo_in_ready),
    .in_data(sac_code(out_latch, bipolar)),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );
endmodule

/* File: logic/sac_defs.vh */
// sac_defs.vh: constants for the converter control block
// assumes a 200 MHz system clock; included by its bare name
`ifndef SAC_DEFS_VH
`define SAC_DEFS_VH
`define SAC_CLK_PS 5000
`define SAC_RES_BITS 16
`define SAC_CNT_W 12
// least start pulse, ns
`define SAC_T_START_NS 40
`define SAC_START_CYC ((`SAC_T_START_NS * 1000 + `SAC_CLK_PS - 1) / `SAC_CLK_PS)
// conversion time, 7 us typ, spread over 16 bit decisions (clock cycles per bit)
`define SAC_T_CONV_NS 7000
`define SAC_BIT_CYC (`SAC_T_CONV_NS * 1000 / `SAC_CLK_PS / `SAC_RES_BITS)
// delay from last decision to busy rising, ns
`define SAC_T_BUSY_NS 220
`define SAC_BUSY_CYC (`SAC_T_BUSY_NS * 1000 / `SAC_CLK_PS)
`define SAC_FIFO_DEPTH 8
`define SAC_FIFO_AW 3
`define SAC_ST_IDLE 2'h0
`define SAC_ST_CLEAR 2'h1
`define SAC_ST_DECIDE 2'h2
`define SAC_ST_LATCH 2'h3
`endif

/* File: logic/sac_fifo.v */
// sac_fifo.v: small synchronous fifo holding finished results
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module sac_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_sys,
  input wire rst_b,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  wire full;
  wire empty;
  wire do_wr;
  wire do_rd;
  assign full = (wr_ptr[AW] != rd_ptr[AW]) &&
    (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign do_wr = in_valid && !full;
  assign do_rd = out_ready && !empty;
  always @(posedge clk_sys) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule
